// *** verilog/supervisor_params.svh ***
// constants for the standby fail-safe supervisor
`ifndef SUPERVISOR_PARAMS_SVH
`define SUPERVISOR_PARAMS_SVH
// =========================================
// register offsets
`define ADAPTIVE_CONTROL_ONE_ADDR 8'h36
`define TREE_TEST_ENABLE_ADDR     8'h6F
// =========================================
// field positions
`define CORE_RAIL_LOW_ENABLE_POS  1
`define TREE_TEST_ENABLE_BIT_POS  0
`define CORE_RAIL_FLAG_POS        1
// =========================================
// reset values
`define ADAPTIVE_CONTROL_ONE_RST  8'h00
`define TREE_TEST_ENABLE_RST      8'h00
`define OVERTEMP_TIMER_RST        32'h0000_0000
`define OVERTEMP_TIMER_MAX        32'hFFFF_FFFF
`define UNMAPPED_READ_VALUE       8'h00
// =========================================
// timing: fail-safe timeout in ms, clock in kHz
`define FAILSAFE_TIMEOUT_MS       4600
`define CLOCK_KHZ                 200000
`define FAILSAFE_CYCLES           (`FAILSAFE_TIMEOUT_MS * `CLOCK_KHZ)
`endif

// *** verilog/supervisor_pkg.sv ***
// types for the standby fail-safe supervisor
package supervisor_pkg;
    typedef enum logic [1:0] {
        ST_WAIT_RAIL = 2'b00, // core rail still down, await first access
        ST_COUNTING  = 2'b01, // fail-safe countdown running
        ST_FULLSPEED = 2'b10, // expired, fans forced to full
        ST_NORMAL    = 2'b11  // defaults loaded, normal operation
    } boot_state_t;
endpackage : supervisor_pkg

// *** verilog/standby_failsafe_supervisor.sv ***
// standby fail-safe supervisor: low core rail response, power-up fail-safe and tree test enable
// How it works
// - the low-rail response acts only with the rail-low enable bit of adaptive_control_one set and standby supply.
// - under that condition a rail below its low limit sets bit 1 of the first interrupt status register.
// - the low-rail condition raises the alert only when alert generation for that flag is enabled.
// - while the rail is low, overtemp pin monitoring stops and its timer holds its value.
// - while the rail is low, adaptive fan start-temperature adjustment is suspended.
// - while the rail is low, shutdown requests are ignored.
// - once the rail is back above its limit, all of these are re-enabled and normal operation resumes.
// - writing 1 to bit 0 of tree_test_enable puts the device into the xnor tree board-test mode.
// - at power-up the core rail input is sampled to choose the start-up path.
// - if the rail stays below 0.75 V, defaults are taken on at the first valid addressing transaction.
// - if the rail comes up a 4.6 s fail-safe countdown runs and expiry forces all fans to full speed.
// - a first addressing after expiry stops the fans, loads defaults and starts normal operation.
// - an addressing before expiry gives normal operation with all registers at defaults.
`timescale 1ns/1ps
`include "supervisor_params.svh"
module standby_failsafe_supervisor #(
    parameter int unsigned FAILSAFE_CYCLES = `FAILSAFE_CYCLES // shortenable for simulation
) (
    input  wire logic       sys_clk_i,          // 200 MHz internal clock
    input  wire logic       rst_n_i,            // synchronous power-on reset, active low
    input  wire logic       clk_en_i,           // freezes all state while low
    input  wire logic       reg_wr_i,           // register write strobe
    input  wire logic [7:0] reg_addr_i,         // register address
    input  wire logic [7:0] reg_wdata_i,        // register write data
    output logic      [7:0] reg_rdata_o,        // register read data
    input  wire logic       smbus_addressed_i,  // pulse: valid transaction addressed us
    input  wire logic       standby_supply_i,   // running from standby supply
    input  wire logic       core_rail_below_i,  // rail below programmed low limit
    input  wire logic       core_rail_up_i,     // rail above 0.75 V power-up threshold
    input  wire logic       core_alert_en_i,    // alert enabled for the rail flag
    input  wire logic       status_clear_i,     // pulse: clear the rail flag on status read
    input  wire logic       overtemp_pin_i,     // overtemp pin level
    input  wire logic       shutdown_req_i,     // request to enter shutdown
    output logic            core_rail_flag_o,   // status bit 1 of first status register
    output logic            smbus_alert_o,      // alert request from the rail flag
    output logic [31:0]     overtemp_timer_o,   // accumulated overtemp assertion count
    output logic            start_temp_run_o,   // adaptive start-temperature may adjust
    output logic            shutdown_o,         // device in shutdown
    output logic            fans_full_o,        // force all fans to full speed
    output logic            fans_stop_o,        // one-cycle pulse: stop fans on late access
    output logic            load_defaults_o,    // one-cycle pulse: load default registers
    output logic            tree_test_mode_o    // xnor tree board-test mode
);
    // =========================================
    // register file
    logic [7:0] adaptive_control_one;
    logic [7:0] tree_test_enable;
    wire  wr_adaptive = reg_wr_i && (reg_addr_i == `ADAPTIVE_CONTROL_ONE_ADDR);
    wire  wr_tree     = reg_wr_i && (reg_addr_i == `TREE_TEST_ENABLE_ADDR);
    wire  rd_adaptive = (reg_addr_i == `ADAPTIVE_CONTROL_ONE_ADDR);
    wire  rd_tree     = (reg_addr_i == `TREE_TEST_ENABLE_ADDR);

    // register writes; defaults also reloaded when the boot path says so
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || (clk_en_i && load_defaults_o)) begin
            adaptive_control_one <= `ADAPTIVE_CONTROL_ONE_RST;
            tree_test_enable     <= `TREE_TEST_ENABLE_RST;
        end else if (clk_en_i) begin
            if (wr_adaptive)
                adaptive_control_one <= reg_wdata_i;
            if (wr_tree)
                tree_test_enable <= reg_wdata_i;
        end
    end

    // read mux: unmapped addresses read zero
    assign reg_rdata_o = rd_adaptive ? adaptive_control_one :
                         rd_tree     ? tree_test_enable : `UNMAPPED_READ_VALUE;
    assign tree_test_mode_o = tree_test_enable[`TREE_TEST_ENABLE_BIT_POS];

    // =========================================
    // low core rail response
    wire rail_low_armed = adaptive_control_one[`CORE_RAIL_LOW_ENABLE_POS] && standby_supply_i;
    wire rail_sleep     = rail_low_armed && core_rail_below_i; // clears itself when rail recovers

    // sticky rail flag; a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i)
            core_rail_flag_o <= 1'b0;
        else if (clk_en_i)
            core_rail_flag_o <= rail_sleep | (core_rail_flag_o & ~status_clear_i);
    end
    assign smbus_alert_o = core_rail_flag_o && core_alert_en_i;

    // overtemp timer: frozen during sleep so it keeps the pre-sleep value
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i)
            overtemp_timer_o <= `OVERTEMP_TIMER_RST;
        else if (clk_en_i && !rail_sleep && overtemp_pin_i && overtemp_timer_o != `OVERTEMP_TIMER_MAX)
            overtemp_timer_o <= overtemp_timer_o + 32'h0000_0001;
    end
    assign start_temp_run_o = !rail_sleep;

    // shutdown state follows the request except while the rail is low
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i)
            shutdown_o <= 1'b0;
        else if (clk_en_i && !rail_sleep)
            shutdown_o <= shutdown_req_i;
    end

    // =========================================
    // power-up fail-safe sequencer
    supervisor_pkg::boot_state_t state;
    supervisor_pkg::boot_state_t next_state;
    logic [31:0] countdown;
    logic        next_full;
    logic        next_stop;
    logic        next_load;
    wire         expired = (countdown == 32'h0000_0000);

    // next state; the rail is polled only in the first state after reset
    always_comb begin
        next_state = state;
        next_full  = fans_full_o;
        next_stop  = 1'b0;
        next_load  = 1'b0;
        case (state)
            supervisor_pkg::ST_WAIT_RAIL: begin
                if (smbus_addressed_i) begin
                    next_state = supervisor_pkg::ST_NORMAL;
                    next_load  = 1'b1;
                end else if (core_rail_up_i) begin
                    next_state = supervisor_pkg::ST_COUNTING;
                end
            end
            supervisor_pkg::ST_COUNTING: begin
                if (smbus_addressed_i) begin
                    next_state = supervisor_pkg::ST_NORMAL;
                    next_load  = 1'b1;
                end else if (expired) begin
                    next_state = supervisor_pkg::ST_FULLSPEED;
                    next_full  = 1'b1;
                end
            end
            supervisor_pkg::ST_FULLSPEED: begin
                if (smbus_addressed_i) begin
                    next_state = supervisor_pkg::ST_NORMAL;
                    next_full  = 1'b0;
                    next_stop  = 1'b1;
                    next_load  = 1'b1;
                end
            end
            supervisor_pkg::ST_NORMAL: begin
                next_state = supervisor_pkg::ST_NORMAL;
            end
            default: begin
                next_state = supervisor_pkg::ST_WAIT_RAIL;
                next_full  = 1'b0;
            end
        endcase
    end

    // sequencer flops; countdown only decrements while counting
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state           <= supervisor_pkg::ST_WAIT_RAIL;
            countdown       <= FAILSAFE_CYCLES - 1;
            fans_full_o     <= 1'b0;
            fans_stop_o     <= 1'b0;
            load_defaults_o <= 1'b0;
        end else if (clk_en_i) begin
            state           <= next_state;
            fans_full_o     <= next_full;
            fans_stop_o     <= next_stop;
            load_defaults_o <= next_load;
            if (state == supervisor_pkg::ST_COUNTING && !expired)
                countdown <= countdown - 32'h0000_0001;
        end
    end

    // =========================================
    // checks
    // first access that arrives once the fans are already forced
    sequence s_access_late;
        state == supervisor_pkg::ST_FULLSPEED && smbus_addressed_i;
    endsequence
    // the stop pulse starts with the default-load pulse and lasts exactly one cycle
    sequence s_stop_pulse;
        fans_stop_o && load_defaults_o && !fans_full_o ##1 !fans_stop_o;
    endsequence
    property p_flag_set;
        @(posedge sys_clk_i) disable iff (!rst_n_i) clk_en_i && rail_sleep |=> core_rail_flag_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("rail flag not set");
    property p_no_arm;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            !adaptive_control_one[`CORE_RAIL_LOW_ENABLE_POS] |-> start_temp_run_o;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("response active while disarmed");
    property p_alert;
        @(posedge sys_clk_i) disable iff (!rst_n_i) smbus_alert_o |-> core_alert_en_i && core_rail_flag_o;
    endproperty
    a_alert: assert property (p_alert) else $error("alert without enable");
    property p_timer_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i) rail_sleep |=> $stable(overtemp_timer_o);
    endproperty
    a_timer_hold: assert property (p_timer_hold) else $error("overtemp timer moved in sleep");
    property p_start_temp;
        @(posedge sys_clk_i) disable iff (!rst_n_i) rail_sleep |-> !start_temp_run_o;
    endproperty
    a_start_temp: assert property (p_start_temp) else $error("start temperature not frozen");
    property p_shutdown;
        @(posedge sys_clk_i) disable iff (!rst_n_i) rail_sleep |=> $stable(shutdown_o);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown changed in sleep");
    property p_tree;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && wr_tree && reg_wdata_i[`TREE_TEST_ENABLE_BIT_POS] && !load_defaults_o |=> tree_test_mode_o;
    endproperty
    a_tree: assert property (p_tree) else $error("tree test mode not entered");
    property p_late;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            (clk_en_i and s_access_late) |=> s_stop_pulse;
    endproperty
    a_late: assert property (p_late) else $error("late access did not stop fans");
    property p_early;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && state == supervisor_pkg::ST_COUNTING && smbus_addressed_i
            |=> state == supervisor_pkg::ST_NORMAL && !fans_full_o;
    endproperty
    a_early: assert property (p_early) else $error("early access not honoured");
    property p_never_full;
        @(posedge sys_clk_i) disable iff (!rst_n_i) state == supervisor_pkg::ST_NORMAL |-> !fans_full_o;
    endproperty
    a_never_full: assert property (p_never_full) else $error("fans forced after access");

    // =========================================
    // checks on the low-rail response
    // without the enable bit and standby supply the flag never rises
    property p_disarmed_quiet;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && !rail_low_armed && !core_rail_flag_o |=> !core_rail_flag_o;
    endproperty
    a_disarmed_quiet: assert property (p_disarmed_quiet) else $error("rail flag set while disarmed");

    // a clear cannot drop the flag while the rail is still low, set wins
    property p_flag_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && core_rail_flag_o && (rail_sleep || !status_clear_i) |=> core_rail_flag_o;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("rail flag lost");

    // the alert follows its enable one cycle after the rail goes low
    property p_alert_follow;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && rail_sleep |=> smbus_alert_o == core_alert_en_i;
    endproperty
    a_alert_follow: assert property (p_alert_follow) else $error("alert does not follow enable");

    // after recovery the overtemp timer counts again
    property p_timer_resume;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && !rail_sleep && overtemp_pin_i && overtemp_timer_o != `OVERTEMP_TIMER_MAX
            |=> overtemp_timer_o == $past(overtemp_timer_o) + 32'h0000_0001;
    endproperty
    a_timer_resume: assert property (p_timer_resume) else $error("overtemp timer not counting");

    // outside sleep the shutdown state tracks the request one cycle late
    property p_shutdown_follow;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && !rail_sleep |=> shutdown_o == $past(shutdown_req_i);
    endproperty
    a_shutdown_follow: assert property (p_shutdown_follow) else $error("shutdown not following request");

    // =========================================
    // checks on the power-up sequencer
    // a rail that comes up before any access starts the countdown
    property p_count_start;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && state == supervisor_pkg::ST_WAIT_RAIL && !smbus_addressed_i && core_rail_up_i
            |=> state == supervisor_pkg::ST_COUNTING;
    endproperty
    a_count_start: assert property (p_count_start) else $error("countdown not started");

    // an access while the rail is down loads defaults with no timer
    property p_down_access;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && state == supervisor_pkg::ST_WAIT_RAIL && smbus_addressed_i
            |=> state == supervisor_pkg::ST_NORMAL && load_defaults_o && !fans_full_o;
    endproperty
    a_down_access: assert property (p_down_access) else $error("rail-down access not honoured");

    // expiry with no access forces the fans on the next cycle
    property p_expiry;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && state == supervisor_pkg::ST_COUNTING && expired && !smbus_addressed_i
            |=> state == supervisor_pkg::ST_FULLSPEED && fans_full_o;
    endproperty
    a_expiry: assert property (p_expiry) else $error("expiry did not force fans");

    // forced fans stay forced until a host shows up
    property p_full_hold;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && fans_full_o && !smbus_addressed_i |=> fans_full_o;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("fans released without access");

    // the default-load pulse returns both registers to their reset values
    property p_defaults;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && load_defaults_o
            |=> adaptive_control_one == `ADAPTIVE_CONTROL_ONE_RST && tree_test_enable == `TREE_TEST_ENABLE_RST;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not loaded");

    // the countdown moves by one per enabled cycle while counting
    property p_count_step;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
            clk_en_i && state == supervisor_pkg::ST_COUNTING && !expired
            |=> countdown == $past(countdown) - 32'h0000_0001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("countdown step wrong");
endmodule : standby_failsafe_supervisor

// *** sim/smbus_host_model.sv ***
// behavioural smbus host that addresses the supervisor after a chosen delay
`timescale 1ns/1ps
module smbus_host_model (
    input  wire logic sys_clk_i,   // device clock, host acts on falling edge
    output logic      addressed_o  // one-cycle pulse per valid transaction
);
    // =========================================
    // transaction issue
    initial addressed_o = 1'b0;
    // host may be prompt or slow; the delay decides which side of expiry it lands
    task automatic address(input int unsigned wait_cycles);
        repeat (wait_cycles) @(negedge sys_clk_i);
        addressed_o = 1'b1;
        @(negedge sys_clk_i);
        addressed_o = 1'b0;
    endtask : address
endmodule : smbus_host_model

// *** sim/test_standby_failsafe_supervisor.sv ***
// self-checking bench for the standby fail-safe supervisor
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module test_standby_failsafe_supervisor;
    localparam int unsigned FS = 20; // shortened countdown keeps the run brief
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b0, wr = 1'b0, addr_pulse;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic standby = 1'b0, below = 1'b0, up = 1'b0, alert_en = 1'b0, clr = 1'b0, otp = 1'b0, sd = 1'b0;
    logic flag, alert, run, sd_o, full, stop, dflt, tree;
    logic [31:0] tmr, t0;
    int n_errors = 0, checked = 0;
    // =========================================
    // clock, design and host
    always #2.5 sys_clk = ~sys_clk;
    standby_failsafe_supervisor #(.FAILSAFE_CYCLES(FS)) u_standby_failsafe_supervisor (
        .sys_clk_i(sys_clk), .rst_n_i(rst_n), .clk_en_i(clk_en), .reg_wr_i(wr), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .smbus_addressed_i(addr_pulse), .standby_supply_i(standby),
        .core_rail_below_i(below), .core_rail_up_i(up), .core_alert_en_i(alert_en), .status_clear_i(clr),
        .overtemp_pin_i(otp), .shutdown_req_i(sd), .core_rail_flag_o(flag), .smbus_alert_o(alert),
        .overtemp_timer_o(tmr), .start_temp_run_o(run), .shutdown_o(sd_o), .fans_full_o(full),
        .fans_stop_o(stop), .load_defaults_o(dflt), .tree_test_mode_o(tree));
    smbus_host_model u_smbus_host_model (.sys_clk_i(sys_clk), .addressed_o(addr_pulse));
    // =========================================
    // shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // every scenario starts from a fresh power-up since the boot path is one-way
    task automatic power_up();
        @(negedge sys_clk);
        {rst_n, standby, below, up, alert_en, clr, otp, sd} = '0;
        clk_en = 1'b1;
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
    endtask : power_up
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        addr = a; wdata = d; wr = 1'b1;
        @(negedge sys_clk);
        wr = 1'b0;
    endtask : reg_write
    // =========================================
    // scenarios
    task automatic test_registers();
        power_up();
        addr = 8'h6F; #1 `CHK("tree_rst", 8'h00, rdata)
        reg_write(8'h6F, 8'h01); `CHK("tree_mode", 1'b1, tree)
        `CHK("tree_read", 8'h01, rdata)
        reg_write(8'h50, 8'hA5); `CHK("unmapped", 8'h00, rdata)
        reg_write(8'h6F, 8'h00); `CHK("tree_off", 1'b0, tree)
    endtask : test_registers
    task automatic test_prompt_host();
        power_up(); up = 1'b1;
        reg_write(8'h6F, 8'h01); // dirty a register so the default load shows
        u_smbus_host_model.address(5);
        `CHK("dflt_early", 1'b1, dflt)
        repeat (FS + 10) @(negedge sys_clk);
        `CHK("no_force", 1'b0, full)
        `CHK("tree_dflt_early", 1'b0, tree)
    endtask : test_prompt_host
    task automatic test_late_host();
        power_up(); up = 1'b1;
        repeat (FS + 3) @(negedge sys_clk);
        `CHK("full_speed", 1'b1, full)
        u_smbus_host_model.address(2);
        `CHK("fans_stop", 1'b1, stop)
        `CHK("dflt_late", 1'b1, dflt)
        `CHK("full_off", 1'b0, full)
        @(negedge sys_clk); `CHK("stop_pulse", 1'b0, stop)
    endtask : test_late_host
    task automatic test_rail_down();
        power_up();
        repeat (FS + 5) @(negedge sys_clk);
        `CHK("no_timer", 1'b0, full)
        reg_write(8'h6F, 8'h01);
        u_smbus_host_model.address(0);
        `CHK("dflt_down", 1'b1, dflt)
        @(negedge sys_clk); `CHK("tree_dflt_down", 1'b0, tree)
    endtask : test_rail_down
    task automatic test_sleep();
        power_up(); {standby, below, alert_en, otp} = 4'hF;
        repeat (3) @(negedge sys_clk);
        `CHK("flag_gated", 1'b0, flag)
        reg_write(8'h36, 8'h02); @(negedge sys_clk);
        `CHK("flag_set", 1'b1, flag)
        `CHK("alert_on", 1'b1, alert)
        `CHK("start_frozen", 1'b0, run)
        t0 = tmr; sd = 1'b1; alert_en = 1'b0;
        repeat (3) @(negedge sys_clk);
        `CHK("timer_held", t0, tmr)
        `CHK("no_shutdown", 1'b0, sd_o)
        `CHK("alert_masked", 1'b0, alert)
        clr = 1'b1; @(negedge sys_clk); clr = 1'b0; // clear while still low must lose
        `CHK("flag_kept", 1'b1, flag)
        below = 1'b0; repeat (2) @(negedge sys_clk);
        `CHK("start_back", 1'b1, run)
        `CHK("shutdown_back", 1'b1, sd_o)
        `CHK("timer_runs", 1'b1, tmr != t0)
        clr = 1'b1; @(negedge sys_clk); clr = 1'b0;
        `CHK("flag_clear", 1'b0, flag)
    endtask : test_sleep
    // =========================================
    // main sequence and watchdog
    initial begin
        test_registers();
        test_prompt_host();
        test_late_host();
        test_rail_down();
        test_sleep();
        finish_test();
    end
    // five scenarios need well under a thousand cycles
    initial begin
        #20000;
        n_errors++;
        finish_test();
    end
endmodule : test_standby_failsafe_supervisor
